// [hw/uart_ctl_pkg.sv]
// Purpose: Constants and types shared by the serial port control block
// Assumes: 250 MHz system clock, AXI4-Lite register access
// Notes on behaviour
// - Two mode bits select one of four modes
// - Filter on: ninth bit zero raises no flag in modes 2/3
// - Reception only while receive enable is set
// - Modes 2/3 send tx_ninth_bit as ninth bit
// - tx_ninth_bit unbuffered, sampled when ninth bit shifts
// - Modes 2/3 store received ninth bit
// - Transmit flag set when ready; software clears
// - Mode 0 receive flag after eighth bit
// - Other modes receive flag after stop bit
package uart_ctl_pkg;
   // ==========================================
   // Register map
   localparam logic [7:0] ctrl_offset = 8'h00;
   localparam logic [7:0] txdata_offset = 8'h04;
   localparam logic [7:0] rxdata_offset = 8'h08;
   localparam logic [7:0] baud_offset = 8'h0c;
   localparam logic [7:0] ctrl_reset = 8'h00;
   localparam logic [15:0] baud_reset = 16'h0010;
   // ==========================================
   // Control field positions
   localparam int rx_int_pos = 0;
   localparam int tx_int_pos = 1;
   localparam int rx_ninth_pos = 2;
   localparam int tx_ninth_pos = 3;
   localparam int rx_enable_pos = 4;
   localparam int mp_filter_pos = 5;
   localparam int mode_low_pos = 6;
   localparam int mode_high_pos = 7;
   // ==========================================
   // Fixed bit-time divisors
   localparam logic [15:0] mode0_div = 16'd16;
   localparam logic [15:0] mode2_div = 16'd32;
   localparam logic [1:0] axi_okay = 2'b00;
   localparam logic [1:0] axi_slverr = 2'b10;
   typedef enum logic [1:0] {mode_shift, mode_8bit, mode_9fixed, mode_9var} mode_t;
endpackage : uart_ctl_pkg

// [hw/buf_if.sv]
// Purpose: Valid/ready byte stream between modules
// Assumes: One clock
// Notes: Payload carries data plus ninth bit
interface buf_if;
   logic valid;
   logic ready;
   logic [8:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface : buf_if

// [hw/skid_buf.sv]
// Purpose: Two-entry buffer for received bytes
// Assumes: Same clock both sides
// Notes: Full when two entries held
module skid_buf #(
   parameter int width = 9
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   buf_if.dst in_s,
   buf_if.src out_s
);
   typedef struct packed {
      logic [1:0][8:0] mem;
      logic [1:0] cnt;
   } state_t;
   state_t s_q, s_d;
   // Entries are sized for data plus ninth bit only
   if (width != 9) begin : g_width_check
      $error("width must be 9");
   end
   assign in_s.ready = (s_q.cnt != 2'd2);
   assign out_s.valid = (s_q.cnt != 2'd0);
   assign out_s.data = s_q.mem[0];
   always_comb begin
      logic push;
      logic pop;
      push = 1'b0;
      pop = 1'b0;
      s_d = s_q;
      push = in_s.valid && in_s.ready;
      pop = out_s.valid && out_s.ready;
      if (pop) begin
         s_d.mem[0] = s_q.mem[1];
      end
      if (push) begin
         if (s_q.cnt == 2'd0 || (s_q.cnt == 2'd1 && pop)) begin
            s_d.mem[0] = in_s.data;
         end else begin
            s_d.mem[1] = in_s.data;
         end
      end
      s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end
endmodule : skid_buf

// [hw/uart_serial_control.sv]
// Purpose: One serial port channel with its control register
// Assumes: AXI4-Lite slave, 250 MHz clock, rx pin asynchronous
// Notes: Modes 1/3 variable rate from the baud register, in clocks per bit; modes 0/2 fixed
module uart_serial_control (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rxd_pin,
   output logic txd_pin,
   output logic shift_clk
);
   typedef enum logic [1:0] {tx_idle, tx_run} tx_st_t;
   typedef enum logic [1:0] {rx_idle, rx_run} rx_st_t;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [15:0] baud;
      logic aw_got;
      logic [7:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      tx_st_t tx_st;
      logic [10:0] tx_sh;
      logic [3:0] tx_bits;
      logic [15:0] tx_cnt;
      logic txd;
      logic sclk;
      rx_st_t rx_st;
      logic [9:0] rx_sh;
      logic [3:0] rx_bits;
      logic [15:0] rx_cnt;
      logic [1:0] rx_sync;
      logic rx_prev;
   } state_t;
   state_t s_q, s_d;
   buf_if rxb_in();
   buf_if rxb_out();

   // ==========================================
   // Helpers
   function automatic logic [15:0] bit_time(input logic [1:0] m, input logic [15:0] b);
      case (m)
         2'b00: bit_time = uart_ctl_pkg::mode0_div;
         2'b10: bit_time = uart_ctl_pkg::mode2_div;
         default: bit_time = (b == 16'h0000) ? 16'h0001 : b;
      endcase
   endfunction : bit_time

   function automatic logic [3:0] frame_bits(input logic [1:0] m);
      case (m)
         2'b00: frame_bits = 4'd8;
         2'b01: frame_bits = 4'd9;
         default: frame_bits = 4'd10;
      endcase
   endfunction : frame_bits

   // Mode 0 ends after its eighth bit; framed modes run out the stop bit
   function automatic logic [3:0] last_tx_bit(input logic [1:0] m);
      last_tx_bit = (m == 2'b00) ? frame_bits(m) - 4'd1 : frame_bits(m);
   endfunction : last_tx_bit

   skid_buf #(.width(9)) u_rxbuf (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .in_s(rxb_in),
      .out_s(rxb_out)
   );

   // ==========================================
   // Bus handshake outputs
   assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
   assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign txd_pin = s_q.txd;
   assign shift_clk = s_q.sclk;

   always_comb begin
      logic [1:0] mode;
      logic [7:0] wa;
      logic [7:0] ra;
      logic wr_fire;
      logic rx_fin;
      logic [9:0] rsh;
      logic rxd;
      logic [15:0] bt;
      mode = '0;
      wa = '0;
      ra = '0;
      wr_fire = 1'b0;
      rx_fin = 1'b0;
      rsh = '0;
      rxd = 1'b0;
      bt = '0;
      s_d = s_q;
      rxb_in.valid = 1'b0;
      rxb_in.data = '0;
      rxb_out.ready = 1'b0;
      // Mode decode from the two select bits
      mode = {s_q.ctrl[uart_ctl_pkg::mode_high_pos], s_q.ctrl[uart_ctl_pkg::mode_low_pos]};
      s_d.rx_sync = {s_q.rx_sync[0], rxd_pin};
      rxd = s_q.rx_sync[1];
      s_d.rx_prev = rxd;

      // ==========================================
      // Write channel
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      wr_fire = s_q.aw_got && s_q.w_got;
      wa = {s_q.awaddr[7:2], 2'b00};
      if (wr_fire) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = uart_ctl_pkg::axi_okay;
         case (wa)
            uart_ctl_pkg::ctrl_offset: begin
               if (s_q.wstrb[0]) begin
                  s_d.ctrl = s_q.wdata[7:0];
               end
            end
            uart_ctl_pkg::txdata_offset: begin
               // Write while idle starts a frame; busy writes dropped
               if (s_q.wstrb[0] && s_q.tx_st == tx_idle) begin
                  s_d.tx_st = tx_run;
                  s_d.tx_cnt = bit_time(mode, s_q.baud);
                  s_d.tx_bits = '0;
                  // Flag left as is; hardware never clears it
                  if (mode == 2'b00) begin
                     s_d.tx_sh = {3'b111, s_q.wdata[7:0]};
                     s_d.txd = s_q.wdata[0];
                  end else begin
                     s_d.tx_sh = {2'b11, s_q.wdata[7:0], 1'b0};
                     s_d.txd = 1'b0;
                  end
               end
            end
            uart_ctl_pkg::baud_offset: begin
               if (s_q.wstrb[0]) begin
                  s_d.baud[7:0] = s_q.wdata[7:0];
               end
               if (s_q.wstrb[1]) begin
                  s_d.baud[15:8] = s_q.wdata[15:8];
               end
            end
            uart_ctl_pkg::rxdata_offset: ;
            default: s_d.bresp = uart_ctl_pkg::axi_slverr;
         endcase
      end

      // ==========================================
      // Read channel; reading data pops the buffer
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      ra = {s_axi_araddr[7:2], 2'b00};
      if (s_axi_arvalid && s_axi_arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = uart_ctl_pkg::axi_okay;
         s_d.rdata = '0;
         case (ra)
            uart_ctl_pkg::ctrl_offset: s_d.rdata = {24'h000000, s_q.ctrl};
            uart_ctl_pkg::baud_offset: s_d.rdata = {16'h0000, s_q.baud};
            uart_ctl_pkg::txdata_offset: s_d.rdata = '0;
            uart_ctl_pkg::rxdata_offset: begin
               s_d.rdata = {22'h000000, rxb_out.valid, rxb_out.data};
               rxb_out.ready = 1'b1;
            end
            default: s_d.rresp = uart_ctl_pkg::axi_slverr;
         endcase
      end

      // ==========================================
      // Transmitter
      if (s_q.tx_st == tx_run) begin
         if (mode == 2'b00) begin
            s_d.sclk = (s_q.tx_cnt > (uart_ctl_pkg::mode0_div >> 1));
         end
         if (s_q.tx_cnt == 16'h0001) begin
            s_d.tx_cnt = bit_time(mode, s_q.baud);
            s_d.tx_bits = s_q.tx_bits + 4'd1;
            s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
            s_d.txd = s_q.tx_sh[1];
            // Ninth bit read live from the field, not latched
            if (mode[1] && s_q.tx_bits == 4'd8) begin
               s_d.txd = s_q.ctrl[uart_ctl_pkg::tx_ninth_pos];
            end
            if (s_q.tx_bits == last_tx_bit(mode)) begin
               s_d.tx_st = tx_idle;
               s_d.txd = 1'b1;
               s_d.sclk = 1'b1;
               // Only set here; clearing is for software
               s_d.ctrl[uart_ctl_pkg::tx_int_pos] = 1'b1;
            end
         end else begin
            s_d.tx_cnt = s_q.tx_cnt - 16'h0001;
         end
      end

      // ==========================================
      // Receiver; mode 0 samples the line once per mode0_div clocks, no start bit
      if (!s_q.ctrl[uart_ctl_pkg::rx_enable_pos]) begin
         s_d.rx_st = rx_idle;
      end else if (s_q.rx_st == rx_idle) begin
         if (mode == 2'b00 || (s_q.rx_prev && !rxd)) begin
            s_d.rx_st = rx_run;
            s_d.rx_bits = '0;
            bt = bit_time(mode, s_q.baud);
            // Half a bit time puts later samples mid-bit
            s_d.rx_cnt = (mode == 2'b00) ? bt : {1'b0, bt[15:1]};
         end
      end else if (s_q.rx_cnt == 16'h0001) begin
         s_d.rx_cnt = bit_time(mode, s_q.baud);
         s_d.rx_bits = s_q.rx_bits + 4'd1;
         s_d.rx_sh = {rxd, s_q.rx_sh[9:1]};
         rsh = {rxd, s_q.rx_sh[9:1]};
         if (mode != 2'b00 && s_q.rx_bits == 4'd0 && rxd) begin
            s_d.rx_st = rx_idle;
         end
         if (mode == 2'b00 && s_q.rx_bits == 4'd7) begin
            rx_fin = 1'b1;
            rsh = {2'b00, rxd, s_q.rx_sh[9:3]};
         end
         if (mode != 2'b00 && s_q.rx_bits == frame_bits(mode)) begin
            rx_fin = 1'b1;
            if (mode == 2'b01) begin
               rsh = {1'b0, rxd, s_q.rx_sh[9:2]};
            end
         end
      end else begin
         s_d.rx_cnt = s_q.rx_cnt - 16'h0001;
      end
      if (rx_fin) begin
         s_d.rx_st = rx_idle;
         // Filter drops frames with ninth bit zero in modes 2/3
         if (!(s_q.ctrl[uart_ctl_pkg::mp_filter_pos] && mode[1] && !rsh[8])) begin
            s_d.ctrl[uart_ctl_pkg::rx_int_pos] = 1'b1;
            if (mode != 2'b00) begin
               s_d.ctrl[uart_ctl_pkg::rx_ninth_pos] = rsh[8];
            end
            // Full buffer drops byte; flag still set for software
            rxb_in.valid = 1'b1;
            rxb_in.data = {rsh[8], rsh[7:0]};
         end
      end
      // Hardware set beats software clear on same cycle
      if (wr_fire && wa == uart_ctl_pkg::ctrl_offset && s_q.wstrb[0]) begin
         if (s_q.ctrl[uart_ctl_pkg::tx_int_pos] != s_d.ctrl[uart_ctl_pkg::tx_int_pos]
             && s_q.tx_st == tx_run && s_d.tx_st == tx_idle) begin
            s_d.ctrl[uart_ctl_pkg::tx_int_pos] = 1'b1;
         end
         if (rx_fin && rxb_in.valid) begin
            s_d.ctrl[uart_ctl_pkg::rx_int_pos] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q <= '0;
         s_q.ctrl <= uart_ctl_pkg::ctrl_reset;
         s_q.baud <= uart_ctl_pkg::baud_reset;
         s_q.txd <= 1'b1;
         s_q.sclk <= 1'b1;
         s_q.rx_sync <= 2'b11;
         s_q.rx_prev <= 1'b1;
         s_q.tx_st <= tx_idle;
         s_q.rx_st <= rx_idle;
      end else if (ce) begin
         s_q <= s_d;
      end
   end
endmodule : uart_serial_control

// [sim/uart_ctl_properties.sv]
// Purpose: Bus and line checks on the serial port top
// Assumes: Bit times of at least 16 clocks
// Notes: Sees top ports only
module uart_ctl_properties (
   input wire logic clk,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic txd_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence wr_taken_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken_s;
      s_axi_arvalid && s_axi_arready;
   endsequence
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   wr_answer_a: assert property (wr_taken_s |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   rd_answer_a: assert property (rd_taken_s |=> s_axi_rvalid)
      else $error("read response late");
   ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   aw_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   unmapped_rd_a: assert property (rd_taken_s ##0 s_axi_araddr == 8'h10 |=>
      s_axi_rresp == 2'b10) else $error("unmapped read not refused");
   // Start bit must stay low for at least 8 clocks, never a glitch
   start_bit_a: assert property ($fell(txd_pin) |-> !txd_pin [*8])
      else $error("short start bit");
endmodule : uart_ctl_properties
bind uart_serial_control uart_ctl_properties u_props (.clk(clk), .reset(reset),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .txd_pin(txd_pin));

// [sim/serial_station.sv]
// Purpose: Remote station on the serial line
// Assumes: Frames are start, nine bits, stop
// Notes: Receiver bit time set by the bench
module serial_station (
   input wire logic clk,
   input wire logic txd_pin,
   output logic rxd_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int rx_clks = 16;
   int n_rx = 0;
   logic [8:0] got;
   // ==========================================
   // Line idles high between frames
   initial rxd_pin = 1'b1;
   task automatic send(input logic [8:0] d, input int clks);
      logic [11:0] f;
      f = {2'b11, d, 1'b0};
      for (int i = 0; i < 12; i++) begin
         rxd_pin <= f[i];
         repeat (clks) @(posedge clk);
      end
   endtask : send
   // Sample mid-bit; in 8-bit frames the ninth sample is the stop bit
   initial forever begin
      @(negedge txd_pin);
      repeat (rx_clks / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         repeat (rx_clks) @(posedge clk);
         got[i] = txd_pin;
      end
      n_rx++;
   end
endmodule : serial_station

// [sim/tb.sv]
// Purpose: Register and line tests of the serial port
// Assumes: Baud register left at its reset value
// Notes: Mode 0 not exercised
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic txd, rxd, sclk;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [1:0] bresp, rresp, r;
   int bad_count = 0;
   int n_tests = 0;
   uart_serial_control u_dut (.clk(clk), .reset(reset), .ce(1'b1), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxd_pin(rxd),
      .txd_pin(txd), .shift_clk(sclk));
   serial_station u_sta (.clk(clk), .txd_pin(txd), .rxd_pin(rxd));
   initial forever #2 clk = ~clk;
   // ==========================================
   // Checking and closing
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   // ==========================================
   // Bus tasks; handshakes judged at the falling edge, where all is settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tq;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tq = bvalid;
         r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tq) begin
            bready <= 1'b0;
            return;
         end
      end
      chk("write wait", 0, 1);
      close_out();
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic ta, tq;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(negedge clk);
         ta = arvalid && arready;
         tq = rvalid;
         v = rdata;
         r = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tq) begin
            rready <= 1'b0;
            return;
         end
      end
      chk("read wait", 0, 1);
      close_out();
   endtask : rd
   task automatic poll(input int pos);
      for (int n = 0; n < 150; n++) begin
         rd(8'h00);
         if (v[pos] === 1'b1) return;
      end
      chk("flag wait", 0, 1);
      close_out();
   endtask : poll
   // ==========================================
   // Scenarios
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      repeat (12) @(posedge clk);
      chk("line idle", {sclk, txd}, 2'b11);
      reset <= 1'b0;
      rd(8'h00);
      chk("ctrl reset", v, 32'h0);
      rd(8'h0c);
      chk("baud reset", v, 32'h10);
      rd(8'h10);
      chk("unmapped read", r, 2'b10);
      wr(8'h10, 32'h0);
      chk("unmapped write", r, 2'b10);
      // Ninth bit alternates so a stale frame cannot pass
      for (int m = 1; m < 4; m++) begin
         wr(8'h00, {24'h0, m[1:0], 2'b00, m[0], 3'b000});
         u_sta.rx_clks = (m == 2) ? 32 : 16;
         wr(8'h04, {24'h0, 8'h5a ^ m[7:0]});
         chk("tx write", r, 2'b00);
         poll(1);
         chk("tx count", u_sta.n_rx, m);
         chk("tx frame", u_sta.got, {m[0], 8'h5a ^ m[7:0]});
      end
      wr(8'h04, 32'h00000077);
      rd(8'h00);
      chk("tx flag kept", v[1], 1'b1);
      wr(8'h00, 32'hd0);
      u_sta.send(9'h13c, 16);
      poll(0);
      chk("rx ninth", v[2], 1'b1);
      rd(8'h08);
      chk("rx data", v, 32'h33c);
      wr(8'h00, 32'hf0);
      u_sta.send(9'h055, 16);
      rd(8'h00);
      chk("filtered flag", v[0], 1'b0);
      u_sta.send(9'h1aa, 16);
      poll(0);
      u_sta.send(9'h1bb, 16);
      rd(8'h08);
      chk("rx first", v, 32'h3aa);
      rd(8'h08);
      chk("rx second", v, 32'h3bb);
      rd(8'h08);
      chk("rx empty", v[9], 1'b0);
      wr(8'h00, 32'hc0);
      u_sta.send(9'h1ff, 16);
      rd(8'h00);
      chk("rx disabled", v[0], 1'b0);
      close_out();
   end
endmodule : tb
